// ### verilog/lpbc_defines.vh
// Overview of operation
// - in wait, an enabled interrupt from an active module wakes the cpu
// - wake from wait by interrupt starts stacking one cycle later
// - cpu clock is gated off in wait; active modules keep running
// - wait also ends on reset, or on break in emulation mode
// - break taken during wait sets the break-in-stop-wait flag
// - watchdog runs in wait when watchdog disable is 0
// - stop entry resets the integration counter and gates all clocks
// - interrupt ends stop; stacking waits for the recovery delay
// - reset or break also ends stop
// - in stop both twice and four-times bus clock enables are off
// - recovery is 4096 cycles, or 32 when short recovery is set
// - with break enable set, a 16-bit address match raises a break
// - break enable at bit 7, cleared by writing 0 and by reset
// - break active set by hardware on a match, cleared by reset
// - writing 1 to break active raises a break interrupt
// - break address held in high and low bytes, reset to zero
// - break starts after the current instruction, or at once on last
`ifndef LPBC_DEFINES_VH
`define LPBC_DEFINES_VH
`define LPBC_OFS_CTRL 12'h000
`define LPBC_OFS_ADDR_HI 12'h004
`define LPBC_OFS_ADDR_LO 12'h008
`define LPBC_OFS_STATUS 12'h00c
`define LPBC_OFS_CONFIG 12'h010
`define LPBC_BIT_BRK_EN 7
`define LPBC_BIT_BRK_ACT 6
`define LPBC_BIT_BREAK_IN_STOP_WAIT_FLAG 1
`define LPBC_BIT_SHORT_REC 7
`define LPBC_BIT_WDOG_DIS 0
`define LPBC_RST_BYTE 8'h00
`define LPBC_RST_CONFIG 8'h00
`define LPBC_REC_LONG 4096
`define LPBC_REC_SHORT 32
`endif

// ### verilog/lpbc_sync.v
`timescale 1ns/10ps
module lpbc_sync #(
  parameter WIDTH = 1
) (
  input wire i_clk,
  input wire i_rst,
  input wire i_ce,
  input wire [WIDTH-1:0] i_d,
  output wire [WIDTH-1:0] o_q
);
  reg [WIDTH-1:0] meta_ff;
  reg [WIDTH-1:0] sync_ff;
  always @(posedge i_clk) begin
    if (i_rst) begin
      meta_ff <= {WIDTH{1'b0}};
      sync_ff <= {WIDTH{1'b0}};
    end else if (i_ce) begin
      meta_ff <= i_d;
      sync_ff <= meta_ff;
    end
  end
  assign o_q = sync_ff;
endmodule

// ### verilog/lpbc_brk_cmp.v
`timescale 1ns/10ps
module lpbc_brk_cmp (
  input wire i_clk,
  input wire i_rst,
  input wire i_ce,
  input wire i_en,
  input wire i_valid,
  input wire [15:0] i_bus_addr,
  input wire [7:0] i_hi,
  input wire [7:0] i_lo,
  output wire o_match
);
  reg match_ff;
  wire hit = i_valid && (i_bus_addr == {i_hi, i_lo});
  always @(posedge i_clk) begin
    if (i_rst) begin
      match_ff <= 1'b0;
    end else if (i_ce) begin
      match_ff <= i_en && hit;
    end
  end
  assign o_match = match_ff;
endmodule

// ### verilog/lpbc_top.v
`timescale 1ns/10ps
`include "lpbc_defines.vh"
module lpbc_top #(
  parameter REC_LONG = `LPBC_REC_LONG,
  parameter REC_SHORT = `LPBC_REC_SHORT
) (
  // clock, reset, enable
  input wire I_MCLK,
  input wire I_RST,
  input wire I_CE,
  // apb slave
  input wire I_PSEL,
  input wire I_PENABLE,
  input wire I_PWRITE,
  input wire [11:0] I_PADDR,
  input wire [31:0] I_PWDATA,
  output reg [31:0] O_PRDATA,
  output wire O_PREADY,
  output wire O_PSLVERR,
  // cpu core side
  input wire I_WAIT_REQ,
  input wire I_STOP_REQ,
  input wire I_INSTR_LAST,
  input wire I_BUS_VALID,
  input wire [15:0] I_BUS_ADDR,
  input wire I_EMUL_MODE,
  input wire I_BREAK_IN_STOP_WAIT_FLAG_CLR,
  // peripheral wake requests, from pins
  input wire I_MOD_IRQ,
  input wire I_MOD_IRQ_EN,
  // low-power and break outputs
  output wire O_CPU_CLK_EN,
  output wire O_TWICE_BUS_CLK_EN,
  output wire O_FOUR_BUS_CLK_EN,
  output wire O_WDOG_RUN,
  output wire O_SIM_CNT_CLR,
  output reg O_STACK_START,
  output reg O_BREAK_IRQ,
  output wire O_IN_WAIT,
  output wire O_IN_STOP,
  output wire [11:0] O_SIM_CNT
);
  localparam ST_RUN = 2'd0;
  localparam ST_WAIT = 2'd1;
  localparam ST_STOP = 2'd2;
  localparam ST_REC = 2'd3;
  localparam [2:0] SEL_NONE = 3'd0;
  localparam [2:0] SEL_CTRL = 3'd1;
  localparam [2:0] SEL_HI = 3'd2;
  localparam [2:0] SEL_LO = 3'd3;
  localparam [2:0] SEL_STAT = 3'd4;
  localparam [2:0] SEL_CFG = 3'd5;
  // recovery counts cut to the 13-bit counter on purpose
  localparam [12:0] REC_LONG_W = REC_LONG[12:0];
  localparam [12:0] REC_SHORT_W = REC_SHORT[12:0];


  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg brk_en_ff;
  reg brk_act_ff;
  reg break_in_stop_wait_flag_ff;
  reg [7:0] addr_hi_ff;
  reg [7:0] addr_lo_ff;
  reg short_rec_ff;
  reg wdog_dis_ff;
  reg [12:0] rec_cnt_ff;
  reg [12:0] nxt_rec_cnt;
  reg [11:0] sim_cnt_ff;
  reg brk_pend_ff;
  reg nxt_stack;
  wire irq_sync;
  wire irq_en_sync;
  wire addr_match;

  // wake pins are asynchronous, two flops before use
  lpbc_sync #(
    .WIDTH(2)
  ) u_sync (
    .i_clk(I_MCLK),
    .i_rst(I_RST),
    .i_ce(I_CE),
    .i_d({I_MOD_IRQ, I_MOD_IRQ_EN}),
    .o_q({irq_sync, irq_en_sync})
  );

  lpbc_brk_cmp u_cmp (
    .i_clk(I_MCLK),
    .i_rst(I_RST),
    .i_ce(I_CE),
    .i_en(brk_en_ff),
    .i_valid(I_BUS_VALID),
    .i_bus_addr(I_BUS_ADDR),
    .i_hi(addr_hi_ff),
    .i_lo(addr_lo_ff),
    .o_match(addr_match)
  );

  // apb decode, zero-wait slave
  function [2:0] dec;
    input [11:0] a;
    begin
      if (a == `LPBC_OFS_CTRL) begin
        dec = SEL_CTRL;
      end else if (a == `LPBC_OFS_ADDR_HI) begin
        dec = SEL_HI;
      end else if (a == `LPBC_OFS_ADDR_LO) begin
        dec = SEL_LO;
      end else if (a == `LPBC_OFS_STATUS) begin
        dec = SEL_STAT;
      end else if (a == `LPBC_OFS_CONFIG) begin
        dec = SEL_CFG;
      end else begin
        dec = SEL_NONE;
      end
    end
  endfunction

  // read mux, unmapped offsets read as zero
  function [31:0] rd_word;
    input [2:0] s;
    begin
      rd_word = 32'h00000000;
      if (s == SEL_CTRL) begin
        rd_word[`LPBC_BIT_BRK_EN] = brk_en_ff;
        rd_word[`LPBC_BIT_BRK_ACT] = brk_act_ff;
      end else if (s == SEL_HI) begin
        rd_word[7:0] = addr_hi_ff;
      end else if (s == SEL_LO) begin
        rd_word[7:0] = addr_lo_ff;
      end else if (s == SEL_STAT) begin
        rd_word[`LPBC_BIT_BREAK_IN_STOP_WAIT_FLAG] = break_in_stop_wait_flag_ff;
      end else if (s == SEL_CFG) begin
        rd_word[`LPBC_BIT_SHORT_REC] = short_rec_ff;
        rd_word[`LPBC_BIT_WDOG_DIS] = wdog_dis_ff;
      end
    end
  endfunction

  wire acc = I_PSEL && I_PENABLE;
  wire [2:0] sel = dec(I_PADDR);
  wire wr = acc && I_PWRITE && I_CE;
  wire wr_ctrl = wr && (sel == SEL_CTRL);
  wire wr_stat = wr && (sel == SEL_STAT);
  // zero wait: every register answers at once
  assign O_PREADY = 1'b1;
  assign O_PSLVERR = acc && (sel == SEL_NONE);

  wire wake_irq = irq_sync && irq_en_sync;
  wire sw_brk = wr_ctrl && I_PWDATA[`LPBC_BIT_BRK_ACT];
  // break on last cycle or next
  wire brk_go = (addr_match || brk_pend_ff) && I_INSTR_LAST;
  wire brk_now = brk_go || sw_brk;
  // break exits wait only in emulation
  wire wait_brk = brk_now && I_EMUL_MODE;

  always @* begin
    nxt_state = state_ff;
    nxt_stack = 1'b0;
    nxt_rec_cnt = rec_cnt_ff;
    case (state_ff)
      ST_RUN: begin
        if (I_STOP_REQ) begin
          nxt_state = ST_STOP;
        end else if (I_WAIT_REQ) begin
          nxt_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (wake_irq) begin
          nxt_state = ST_RUN;
          nxt_stack = 1'b1;
        end else if (wait_brk) begin
          nxt_state = ST_RUN;
        end
      end
      ST_STOP: begin
        if (brk_now) begin
          nxt_state = ST_RUN;
        end else if (wake_irq) begin
          nxt_state = ST_REC;
          nxt_rec_cnt = short_rec_ff ? REC_SHORT_W : REC_LONG_W;
        end
      end
      default: begin
        if (rec_cnt_ff <= 13'd1) begin
          nxt_state = ST_RUN;
          nxt_stack = 1'b1;
          nxt_rec_cnt = 13'd0;
        end else begin
          nxt_rec_cnt = rec_cnt_ff - 13'd1;
        end
      end
    endcase
  end

  always @(posedge I_MCLK) begin
    if (I_RST) begin
      state_ff <= ST_RUN;
      rec_cnt_ff <= 13'd0;
      O_STACK_START <= 1'b0;
    end else if (I_CE) begin
      state_ff <= nxt_state;
      rec_cnt_ff <= nxt_rec_cnt;
      O_STACK_START <= nxt_stack;
    end
  end

  always @(posedge I_MCLK) begin
    if (I_RST) begin
      sim_cnt_ff <= 12'h000;
    end else if (I_CE) begin
      if (state_ff == ST_STOP || (state_ff == ST_RUN && I_STOP_REQ)) begin
        sim_cnt_ff <= 12'h000;
      end else begin
        sim_cnt_ff <= sim_cnt_ff + 12'h001;
      end
    end
  end
  assign O_SIM_CNT_CLR = (state_ff == ST_STOP);
  assign O_SIM_CNT = sim_cnt_ff;

  assign O_CPU_CLK_EN = (state_ff == ST_RUN);
  assign O_TWICE_BUS_CLK_EN = (state_ff != ST_STOP);
  assign O_FOUR_BUS_CLK_EN = (state_ff != ST_STOP);
  assign O_WDOG_RUN = !wdog_dis_ff && (state_ff != ST_STOP);
  assign O_IN_WAIT = (state_ff == ST_WAIT);
  assign O_IN_STOP = (state_ff == ST_STOP);

  always @(posedge I_MCLK) begin
    if (I_RST) begin
      brk_en_ff <= 1'b0;
      brk_act_ff <= 1'b0;
      break_in_stop_wait_flag_ff <= 1'b0;
      brk_pend_ff <= 1'b0;
      O_BREAK_IRQ <= 1'b0;
      addr_hi_ff <= `LPBC_RST_BYTE;
      addr_lo_ff <= `LPBC_RST_BYTE;
      short_rec_ff <= 1'b0;
      wdog_dis_ff <= 1'b0;
    end else if (I_CE) begin
      O_BREAK_IRQ <= brk_now;
      if (brk_go) begin
        brk_pend_ff <= 1'b0;
      // disabling breaks also drops a break still waiting
      end else if (wr_ctrl && !I_PWDATA[`LPBC_BIT_BRK_EN]) begin
        brk_pend_ff <= 1'b0;
      end else if (addr_match) begin
        brk_pend_ff <= 1'b1;
      end
      if (wr_ctrl) begin
        brk_en_ff <= I_PWDATA[`LPBC_BIT_BRK_EN];
      end
      if (addr_match) begin
        brk_act_ff <= 1'b1;
      end else if (wr_ctrl) begin
        brk_act_ff <= I_PWDATA[`LPBC_BIT_BRK_ACT];
      end
      if (brk_now && (state_ff == ST_WAIT || state_ff == ST_STOP)) begin
        break_in_stop_wait_flag_ff <= 1'b1;
      end else if (I_BREAK_IN_STOP_WAIT_FLAG_CLR || (wr_stat && !I_PWDATA[`LPBC_BIT_BREAK_IN_STOP_WAIT_FLAG])) begin
        break_in_stop_wait_flag_ff <= 1'b0;
      end
      if (wr && sel == SEL_HI) begin
        addr_hi_ff <= I_PWDATA[7:0];
      end
      if (wr && sel == SEL_LO) begin
        addr_lo_ff <= I_PWDATA[7:0];
      end
      // software keeps this clear for crystals
      if (wr && sel == SEL_CFG) begin
        short_rec_ff <= I_PWDATA[`LPBC_BIT_SHORT_REC];
        wdog_dis_ff <= I_PWDATA[`LPBC_BIT_WDOG_DIS];
      end
    end
  end

  always @(posedge I_MCLK) begin
    if (I_RST) begin
      O_PRDATA <= 32'h00000000;
    end else if (I_CE && I_PSEL && !I_PENABLE && !I_PWRITE) begin
      O_PRDATA <= rd_word(sel);
    end
  end
endmodule

// ### tb/lpbc_chk_sva.sv
`timescale 1ns/10ps
module lpbc_chk (
  // clock and reset
  input logic I_MCLK,
  input logic I_RST,
  // inputs watched
  input logic I_PSEL,
  input logic I_INSTR_LAST,
  // outputs watched
  input logic O_CPU_CLK_EN,
  input logic O_TWICE_BUS_CLK_EN,
  input logic O_FOUR_BUS_CLK_EN,
  input logic O_WDOG_RUN,
  input logic O_SIM_CNT_CLR,
  input logic O_STACK_START,
  input logic O_BREAK_IRQ,
  input logic O_IN_WAIT,
  input logic O_IN_STOP,
  input logic [11:0] O_SIM_CNT
);
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (I_RST);
  sequence s_stopped;
    O_IN_STOP ##1 O_IN_STOP;
  endsequence
  sequence s_woke;
    O_STACK_START && $past(!O_CPU_CLK_EN && !O_IN_WAIT && !O_IN_STOP);
  endsequence
  a_stop_gates: assert property (
    O_IN_STOP |-> !O_TWICE_BUS_CLK_EN && !O_FOUR_BUS_CLK_EN)
    else $error("bus clocks running in stop");
  a_wait_cpu_off: assert property (
    O_IN_WAIT |-> !O_CPU_CLK_EN && O_FOUR_BUS_CLK_EN)
    else $error("wrong clock enables in wait");
  a_run_clk: assert property (
    $fell(O_IN_WAIT) && !O_IN_STOP |-> O_CPU_CLK_EN)
    else $error("cpu clock off after wake");
  a_stop_cnt: assert property (
    s_stopped |-> O_SIM_CNT_CLR && O_SIM_CNT == 12'h000)
    else $error("counter not cleared in stop");
  a_stack_run: assert property (
    O_STACK_START |-> O_CPU_CLK_EN && $past(!O_CPU_CLK_EN))
    else $error("stacking outside a wake");
  a_stop_recov: assert property (
    s_woke |-> $past(!O_CPU_CLK_EN && !O_IN_WAIT && !O_IN_STOP, 32))
    else $error("stacking before recovery");
  a_wdog_wait: assert property (
    $rose(O_IN_WAIT) |-> O_WDOG_RUN == $past(O_WDOG_RUN))
    else $error("watchdog changed on wait");
  a_break_last: assert property (
    O_BREAK_IRQ && !$past(I_PSEL) |-> $past(I_INSTR_LAST))
    else $error("break not at instruction end");
endmodule
bind lpbc_top lpbc_chk u_lpbc_chk (.*);

// ### tb/lpbc_cpu_model.sv
`timescale 1ns/10ps
module lpbc_cpu_model (
  // clock
  input wire logic i_clk,
  // wake command
  input wire logic i_wake,
  // towards the block
  output logic o_irq = 1'b0,
  output logic o_irq_en,
  output logic o_last
);
  logic [1:0] cyc_ff = 2'h0;
  // three-cycle instructions, so breaks must wait
  always @(posedge i_clk) begin
    cyc_ff <= (cyc_ff == 2'h2) ? 2'h0 : cyc_ff + 2'h1;
    o_irq <= i_wake;
  end
  assign o_last = (cyc_ff == 2'h2);
  assign o_irq_en = 1'b1;
endmodule

// ### tb/tb.sv
`timescale 1ns/10ps
module tb;
  typedef struct {logic [11:0] a; logic [31:0] d, q; logic e;} lpbc_row_t;
  logic I_MCLK = 0, I_RST = 1, I_CE = 1, I_PSEL = 0, I_PENABLE = 0;
  logic I_PWRITE = 0, I_WAIT_REQ = 0, I_STOP_REQ = 0, I_BUS_VALID = 0;
  logic I_EMUL_MODE = 0, I_BREAK_IN_STOP_WAIT_FLAG_CLR = 0, wake = 0, er;
  logic [11:0] I_PADDR = 0;
  logic [31:0] I_PWDATA = 0, rd;
  logic [15:0] I_BUS_ADDR = 0;
  wire I_MOD_IRQ, I_MOD_IRQ_EN, I_INSTR_LAST, O_PREADY, O_PSLVERR;
  wire O_CPU_CLK_EN, O_TWICE_BUS_CLK_EN, O_FOUR_BUS_CLK_EN, O_WDOG_RUN;
  wire O_SIM_CNT_CLR, O_STACK_START, O_BREAK_IRQ, O_IN_WAIT, O_IN_STOP;
  wire [31:0] O_PRDATA;
  wire [11:0] O_SIM_CNT;
  int errors = 0, num_checks = 0, brk_n = 0, stk_n = 0, cyc = 0, t, n;
  int stk_cyc = 0;
  lpbc_row_t rows[5] = '{'{12'h000, 32'h80, 32'h80, 1'b0},
    '{12'h004, 32'h12, 32'h12, 1'b0}, '{12'h008, 32'h34, 32'h34, 1'b0},
    '{12'h010, 32'h80, 32'h80, 1'b0}, '{12'h020, 32'hff, 32'h00, 1'b1}};
  // short long count keeps the run brief
  lpbc_top #(.REC_LONG(40)) u_lpbc_top (.*);
  lpbc_cpu_model u_lpbc_cpu_model (.i_clk(I_MCLK), .i_wake(wake),
    .o_irq(I_MOD_IRQ), .o_irq_en(I_MOD_IRQ_EN), .o_last(I_INSTR_LAST));
  initial forever #12.5 I_MCLK = ~I_MCLK;
  always @(posedge I_MCLK) begin
    cyc++;
    if (O_STACK_START) begin
      stk_n++;
      stk_cyc = cyc;
    end
    if (O_BREAK_IRQ) brk_n++;
  end
  task chk(input logic [63:0] g, input logic [63:0] e);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    I_PSEL <= 1;
    I_PWRITE <= w;
    I_PADDR <= a;
    I_PWDATA <= d;
    @(posedge I_MCLK);
    I_PENABLE <= 1;
    do @(posedge I_MCLK); while (O_PREADY !== 1'b1);
    rd = O_PRDATA;
    er = O_PSLVERR;
    I_PSEL <= 0;
    I_PENABLE <= 0;
    @(posedge I_MCLK);
  endtask
  task lp(input logic s);
    I_STOP_REQ <= s;
    I_WAIT_REQ <= !s;
    @(posedge I_MCLK);
    I_STOP_REQ <= 0;
    I_WAIT_REQ <= 0;
    repeat (2) @(posedge I_MCLK);
  endtask
  task brk(input logic [15:0] a, input int e);
    n = brk_n;
    I_BUS_ADDR <= a;
    I_BUS_VALID <= 1;
    @(posedge I_MCLK);
    I_BUS_VALID <= 0;
    repeat (6) @(posedge I_MCLK);
    chk(brk_n - n, e);
  endtask
  task stop_wake(input int lo);
    lp(1);
    chk({O_IN_STOP, O_FOUR_BUS_CLK_EN, O_TWICE_BUS_CLK_EN}, 3'h4);
    chk(O_SIM_CNT, 12'h000);
    t = cyc;
    wake <= 1;
    repeat (60) @(posedge I_MCLK);
    wake <= 0;
    chk(stk_cyc - t >= lo && stk_cyc - t < lo + 8, 1);
    repeat (4) @(posedge I_MCLK);
  endtask
  task end_sim;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // a hang never gets past this
  initial begin
    #200000;
    errors++;
    end_sim;
  end
  initial begin
    repeat (5) @(posedge I_MCLK);
    I_RST <= 0;
    @(posedge I_MCLK);
    for (int i = 0; i < 5; i++) begin
      apb(0, 12'(4 * i), 0);
      chk(rd, 0);
    end
    foreach (rows[i]) begin
      apb(1, rows[i].a, rows[i].d);
      apb(0, rows[i].a, 0);
      chk({er, rd}, {rows[i].e, rows[i].q});
    end
    I_CE <= 0;
    apb(1, 12'h004, 32'h55);
    I_CE <= 1;
    apb(0, 12'h004, 0);
    chk(rd, 32'h12);
    lp(0);
    chk({O_IN_WAIT, O_CPU_CLK_EN, O_WDOG_RUN}, 3'h5);
    n = stk_n;
    wake <= 1;
    repeat (12) @(posedge I_MCLK);
    wake <= 0;
    chk({O_IN_WAIT, 32'(stk_n - n)}, 1);
    repeat (4) @(posedge I_MCLK);
    stop_wake(32);
    apb(1, 12'h010, 0);
    stop_wake(40);
    brk(16'h1235, 0);
    brk(16'h1234, 1);
    apb(0, 12'h000, 0);
    chk(rd, 32'hc0);
    apb(1, 12'h000, 0);
    brk(16'h1234, 0);
    n = brk_n;
    apb(1, 12'h000, 32'h40);
    @(posedge I_MCLK);
    chk(brk_n - n, 1);
    I_EMUL_MODE <= 1;
    apb(1, 12'h000, 32'h80);
    lp(0);
    brk(16'h1234, 1);
    chk(O_IN_WAIT, 0);
    apb(0, 12'h00c, 0);
    chk(rd[1], 1);
    I_BREAK_IN_STOP_WAIT_FLAG_CLR <= 1;
    @(posedge I_MCLK);
    I_BREAK_IN_STOP_WAIT_FLAG_CLR <= 0;
    apb(0, 12'h00c, 0);
    chk(rd, 0);
    lp(0);
    I_RST <= 1;
    repeat (2) @(posedge I_MCLK);
    I_RST <= 0;
    chk({O_IN_WAIT, O_CPU_CLK_EN}, 2'h1);
    end_sim;
  end
endmodule
